// ---- rtl/ppg_top.sv ----
// ppg_top: printer parallel port and general i/o pins
// assumes synchronous register port, one clock, sync active-low reset
//
// What this block does
// - data lines input at reset; direction bit
// - eight bidirectional data lines, 7:5 and 4:0
// - select output low selects printer
// - init output low initialises printer
// - line-advance output low requests auto feed
// - low pulse on strobe latches data
// - general input two read at bit 6
// - mii mode: general input one at bit 5
// - printer mode: input one pin is paper-out
// - mii mode: general input zero at bit 4
// - printer mode: input zero pin is online
// - general output resets 1, drives inverted bit
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppg_top
	import ppg_pkg::*;
#(
	parameter int DATA_LATCH_PULSE_N_LEN = DATA_LATCH_PULSE_N_CYC
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	output logic            irq_out,
	// parallel data lines
	input  wire logic [7:0] parallel_lines_in,
	output logic      [7:0] parallel_lines_out,
	output logic      [7:0] parallel_lines_oe_out,
	// printer status
	input  wire logic       busy_in,
	input  wire logic       ack_n_in,
	input  wire logic       fault_n_in,
	// general inputs, one and zero shared
	input  wire logic       general_in_two_rate_in,
	input  wire logic       general_in_one_duplex_in,
	input  wire logic       general_in_zero_link_in,
	// printer controls
	output logic            printer_choose_n_out,
	output logic            init_n_out,
	output logic            line_advance_n_out,
	output logic            data_latch_pulse_n_out,
	// general output
	output logic            general_out_zero_out
);
	typedef struct packed {
		logic [7:0]          ctrl;
		logic [7:0]          pdata;
		logic                gout;
		logic [ST_WIDTH-1:0] stat;
		logic [ST_WIDTH-1:0] mask;
		logic                ack_d;
		logic                fault_d;
		logic                paper_d;
		logic                busy_d;
		logic                online_d;
		logic [7:0]          rdata;
	} ppg_top_s;

	ppg_top_s st_r;
	ppg_top_s st_nxt;

	logic [7:0] din_s;
	logic [5:0] pins_s;
	logic       busy_s;
	logic       ack_n_s;
	logic       fault_n_s;
	logic       gin2_s;
	logic       gin1_s;
	logic       gin0_s;
	logic       data_latch_pulse_n_start;
	logic       data_latch_pulse_n_done;
	logic       data_latch_pulse_n_n;
	logic       mode_printer;
	logic       paper_out;
	logic       printer_online;
	logic [ST_WIDTH-1:0] ev;
	logic [ST_WIDTH-1:0] clr;

	// ==========================================
	// input synchronisers
	ppg_sync #(.W(8)) u_sync_data (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.d_in       (parallel_lines_in),
		.rst_val_in (8'h00),
		.q_out      (din_s)
	);
	ppg_sync #(.W(6)) u_sync_pins (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.d_in       ({busy_in, ack_n_in, fault_n_in, general_in_two_rate_in,
		              general_in_one_duplex_in, general_in_zero_link_in}),
		.rst_val_in (6'h18),
		.q_out      (pins_s)
	);
	assign busy_s    = pins_s[5];
	assign ack_n_s   = pins_s[4];
	assign fault_n_s = pins_s[3];
	assign gin2_s    = pins_s[2];
	assign gin1_s    = pins_s[1];
	assign gin0_s    = pins_s[0];

	// ==========================================
	// pin sharing
	assign mode_printer   = st_r.ctrl[PPC_MODE_BIT];
	assign paper_out      = mode_printer & gin1_s;
	assign printer_online = mode_printer & gin0_s;

	// ==========================================
	// data strobe
	assign data_latch_pulse_n_start = wr_in && (addr_in == PPC_OFF) && wdata_in[PPC_DATA_LATCH_PULSE_N_BIT];
	ppg_strobe #(.LEN(DATA_LATCH_PULSE_N_LEN)) u_strobe (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.start_in     (data_latch_pulse_n_start),
		.strobe_n_out (data_latch_pulse_n_n),
		.done_out     (data_latch_pulse_n_done)
	);

	// ==========================================
	// events
	always_comb begin
		ev                = '0;
		ev[ST_ACK_BIT]    = st_r.ack_d & ~ack_n_s;
		ev[ST_FAULT_BIT]  = st_r.fault_d & ~fault_n_s;
		ev[ST_PAPER_BIT]  = ~st_r.paper_d & paper_out;
		ev[ST_BUSY_BIT]   = st_r.busy_d & ~busy_s;
		ev[ST_ONLINE_BIT] = ~st_r.online_d & printer_online;
		ev[ST_DATA_LATCH_PULSE_N_BIT]   = data_latch_pulse_n_done;
		clr               = '0;
		if (wr_in && addr_in == STAT_OFF) begin
			clr = wdata_in[ST_WIDTH-1:0];
		end
	end

	// ==========================================
	// register state
	always_comb begin
		st_nxt          = st_r;
		st_nxt.ack_d    = ack_n_s;
		st_nxt.fault_d  = fault_n_s;
		st_nxt.paper_d  = paper_out;
		st_nxt.busy_d   = busy_s;
		st_nxt.online_d = printer_online;
		st_nxt.stat     = (st_r.stat & ~clr) | ev;
		if (wr_in) begin
			unique case (addr_in)
				GIO_OFF:   st_nxt.gout  = ~wdata_in[GIO_OUT0_BIT];
				PPC_OFF: begin
					st_nxt.ctrl               = wdata_in;
					st_nxt.ctrl[PPC_DATA_LATCH_PULSE_N_BIT] = 1'b0;
				end
				IMASK_OFF: st_nxt.mask  = wdata_in[ST_WIDTH-1:0];
				PDATA_OFF: st_nxt.pdata = wdata_in;
				default:   st_nxt.gout  = st_r.gout;
			endcase
		end
		st_nxt.rdata = 8'h00;
		if (rd_in) begin
			unique case (addr_in)
				GIO_OFF: begin
					st_nxt.rdata[GIO_IN2_BIT] = gin2_s;
					st_nxt.rdata[GIO_IN1_BIT] = ~mode_printer & gin1_s;
					st_nxt.rdata[GIO_IN0_BIT] = ~mode_printer & gin0_s;
				end
				PPC_OFF: begin
					st_nxt.rdata                = st_r.ctrl;
					st_nxt.rdata[PPC_DATA_LATCH_PULSE_N_BIT]  = ~data_latch_pulse_n_n;
				end
				STAT_OFF:  st_nxt.rdata = {2'b00, st_r.stat};
				IMASK_OFF: st_nxt.rdata = {2'b00, st_r.mask};
				PDATA_OFF: begin
					st_nxt.rdata = st_r.ctrl[PPC_DRIVE_BIT] ? st_r.pdata : din_s;
				end
				default:   st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r          <= '0;
			st_r.ctrl     <= PPC_RESET;
			st_r.mask     <= MASK_RESET;
			st_r.gout     <= GOUT_RESET;
			st_r.ack_d    <= 1'b1;
			st_r.fault_d  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// outputs
	assign rdata_out              = st_r.rdata;
	assign irq_out                = |(st_r.stat & st_r.mask);
	assign parallel_lines_out     = st_r.pdata;
	assign parallel_lines_oe_out  = {8{st_r.ctrl[PPC_DRIVE_BIT]}};
	assign printer_choose_n_out   = ~st_r.ctrl[PPC_SEL_BIT];
	assign init_n_out             = ~st_r.ctrl[PPC_INIT_BIT];
	assign line_advance_n_out     = ~st_r.ctrl[PPC_LF_BIT];
	assign data_latch_pulse_n_out = data_latch_pulse_n_n;
	assign general_out_zero_out   = st_r.gout;
endmodule
`default_nettype wire

// ---- common/ppg_pkg.sv ----
// ppg_pkg: constants for the printer port and general i/o block
// assumes a byte-wide register port and one 125 MHz clock
package ppg_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] GIO_OFF      = 8'h17;
	localparam logic [7:0] PPC_OFF      = 8'h1a;
	localparam logic [7:0] STAT_OFF     = 8'h1b;
	localparam logic [7:0] IMASK_OFF    = 8'h1c;
	localparam logic [7:0] PDATA_OFF    = 8'h1d;
	// ==========================================
	// general_io_bits fields
	localparam int GIO_OUT0_BIT  = 0;
	localparam int GIO_IN0_BIT   = 4;
	localparam int GIO_IN1_BIT   = 5;
	localparam int GIO_IN2_BIT   = 6;
	// ==========================================
	// printer_port_control fields
	localparam int PPC_DRIVE_BIT = 0;
	localparam int PPC_DATA_LATCH_PULSE_N_BIT  = 1;
	localparam int PPC_LF_BIT    = 2;
	localparam int PPC_INIT_BIT  = 3;
	localparam int PPC_SEL_BIT   = 4;
	localparam int PPC_MODE_BIT  = 5;
	// ==========================================
	// status / interrupt fields
	localparam int ST_ACK_BIT    = 0;
	localparam int ST_FAULT_BIT  = 1;
	localparam int ST_PAPER_BIT  = 2;
	localparam int ST_BUSY_BIT   = 3;
	localparam int ST_ONLINE_BIT = 4;
	localparam int ST_DATA_LATCH_PULSE_N_BIT   = 5;
	localparam int ST_WIDTH      = 6;
	// ==========================================
	// reset values
	localparam logic [7:0] PPC_RESET    = 8'h00;
	localparam logic [5:0] MASK_RESET   = 6'h00;
	localparam logic       GOUT_RESET   = 1'b1;
	// ==========================================
	// timing
	localparam int CLK_MHZ       = 125;
	localparam int DATA_LATCH_PULSE_N_NS       = 1000;
	localparam int DATA_LATCH_PULSE_N_CYC      = (DATA_LATCH_PULSE_N_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_STAGES   = 2;
endpackage

// ---- rtl/ppg_sync.sv ----
// ppg_sync: two-stage synchroniser for a group of levels
// assumes inputs asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module ppg_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// levels
	input  wire logic [W-1:0] d_in,
	input  wire logic [W-1:0] rst_val_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;
	// ==========================================
	// two flops, first read only by second
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_r <= rst_val_in;
			q_r    <= rst_val_in;
		end else begin
			meta_r <= d_in;
			q_r    <= meta_r;
		end
	end
	assign q_out = q_r;
endmodule
`default_nettype wire

// ---- rtl/ppg_strobe.sv ----
// ppg_strobe: low-going strobe pulse of fixed length
// assumes a one-cycle start request
`timescale 1ns/1ps
`default_nettype none
module ppg_strobe
	import ppg_pkg::*;
#(
	parameter int LEN = DATA_LATCH_PULSE_N_CYC
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic start_in,
	output logic      strobe_n_out,
	output logic      done_out
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        act;
		logic        done;
	} ppg_data_latch_pulse_n_s;
	ppg_data_latch_pulse_n_s st_r;
	ppg_data_latch_pulse_n_s st_nxt;
	// ==========================================
	// pulse counter
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (st_r.act) begin
			if (st_r.cnt == 16'(LEN - 1)) begin
				st_nxt.act  = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
			end
		end else if (start_in) begin
			st_nxt.act = 1'b1;
			st_nxt.cnt = 16'h0000;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign strobe_n_out = ~st_r.act;
	assign done_out     = st_r.done;
endmodule
`default_nettype wire

// ---- tb/ppg_printer.sv ----
// ppg_printer: behavioural printer on the parallel port
// assumes strobe and data from ppg_top, same clock
`timescale 1ns/1ps
`default_nettype none
module ppg_printer (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// port side
	input  wire logic [7:0] lines_in,
	input  wire logic       strobe_n_in,
	output logic            busy_out,
	output logic            ack_n_out,
	output logic      [7:0] got_out
);
	logic [2:0] cnt_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_out <= 1'b0;
			ack_n_out <= 1'b1;
			got_out <= 8'h00;
			cnt_r <= 3'h0;
		end else if (!strobe_n_in) begin
			busy_out <= 1'b1;
			got_out <= lines_in;
			cnt_r <= 3'h4;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
			ack_n_out <= (cnt_r != 3'h2);
			if (cnt_r == 3'h1) busy_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/ppg_top_properties.sv ----
// ppg_top_properties: port-level checks of ppg_top
// assumes bind to ppg_top, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module ppg_top_properties
	import ppg_pkg::*;
#(
	parameter int DATA_LATCH_PULSE_N_LEN = DATA_LATCH_PULSE_N_CYC
) (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic [7:0] parallel_lines_out,
	input wire logic [7:0] parallel_lines_oe_out,
	input wire logic       general_in_two_rate_in,
	input wire logic       printer_choose_n_out,
	input wire logic       init_n_out,
	input wire logic       line_advance_n_out,
	input wire logic       data_latch_pulse_n_out,
	input wire logic       general_out_zero_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================
	// strobe length counter
	logic [7:0] low_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || data_latch_pulse_n_out) low_r <= 8'h00;
		else low_r <= low_r + 8'h01;
	end
	sequence s_ctl_wr;
		wr_in && addr_in == PPC_OFF;
	endsequence
	sequence s_gin2_read;
		$stable(general_in_two_rate_in)[*3] ##0 (rd_in && addr_in == GIO_OFF && $past(rst_n_in, 3));
	endsequence
	// ==========================================
	// assertions
	AST_RST_OUT: assert property ($rose(rst_n_in) |-> parallel_lines_oe_out == 8'h00 && general_out_zero_out)
		else $error("outputs wrong after reset");
	AST_OE_WR: assert property (s_ctl_wr |=> parallel_lines_oe_out == {8{$past(wdata_in[PPC_DRIVE_BIT])}})
		else $error("drive enable not taken");
	AST_DATA_WR: assert property (wr_in && addr_in == PDATA_OFF |=> parallel_lines_out == $past(wdata_in))
		else $error("output data not taken");
	AST_SEL: assert property (s_ctl_wr |=> printer_choose_n_out == !$past(wdata_in[PPC_SEL_BIT]))
		else $error("select level wrong");
	AST_INIT: assert property (s_ctl_wr |=> init_n_out == !$past(wdata_in[PPC_INIT_BIT]))
		else $error("init level wrong");
	AST_LF: assert property (s_ctl_wr |=> line_advance_n_out == !$past(wdata_in[PPC_LF_BIT]))
		else $error("line advance level wrong");
	AST_DATA_LATCH_PULSE_N_GO: assert property (s_ctl_wr ##0 wdata_in[PPC_DATA_LATCH_PULSE_N_BIT] && data_latch_pulse_n_out |=> !data_latch_pulse_n_out)
		else $error("strobe did not start");
	AST_DATA_LATCH_PULSE_N_LEN: assert property ($rose(data_latch_pulse_n_out) |-> low_r == DATA_LATCH_PULSE_N_LEN)
		else $error("strobe length wrong");
	AST_GIN2: assert property (s_gin2_read |=> rdata_out[GIO_IN2_BIT] == $past(general_in_two_rate_in))
		else $error("input two read wrong");
	AST_GOUT: assert property (wr_in && addr_in == GIO_OFF |=> general_out_zero_out == !$past(wdata_in[GIO_OUT0_BIT]))
		else $error("general output wrong");
endmodule
bind ppg_top ppg_top_properties #(.DATA_LATCH_PULSE_N_LEN(DATA_LATCH_PULSE_N_LEN)) u_props (.*);
`default_nettype wire

// ---- tb/ppg_top_tb.sv ----
// ppg_top_tb: self-checking bench of ppg_top
// assumes ppg_printer model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module ppg_top_tb
	import ppg_pkg::*;
;
	logic       clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, fault_n_in = 1;
	logic       gin2 = 1, gin1 = 0, gin0 = 0, irq_out, busy, ack_n, sel_n, init_n, lf_n, data_latch_pulse_n_n, gout;
	logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, lines_out, oe_out, lines, got, rv;
	int         failures = 0, checks_done = 0, n;
	assign lines = (lines_out & oe_out) | (8'h1f & ~oe_out);
	always #4 clk_in = ~clk_in;
	ppg_top #(.DATA_LATCH_PULSE_N_LEN(4)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .parallel_lines_in(lines),
		.parallel_lines_out(lines_out), .parallel_lines_oe_out(oe_out), .busy_in(busy), .ack_n_in(ack_n),
		.fault_n_in(fault_n_in), .general_in_two_rate_in(gin2), .general_in_one_duplex_in(gin1),
		.general_in_zero_link_in(gin0), .printer_choose_n_out(sel_n), .init_n_out(init_n),
		.line_advance_n_out(lf_n), .data_latch_pulse_n_out(data_latch_pulse_n_n), .general_out_zero_out(gout));
	ppg_printer u_prn (.clk_in(clk_in), .rst_n_in(rst_n_in), .lines_in(lines), .strobe_n_in(data_latch_pulse_n_n),
		.busy_out(busy), .ack_n_out(ack_n), .got_out(got));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
		@(posedge clk_in); wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in); addr_in <= a; rd_in <= 1'b1;
		@(posedge clk_in); rd_in <= 1'b0;
		@(negedge clk_in); d = rdata_out;
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic t_reset;
		@(negedge clk_in);
		`CHK({oe_out, sel_n, init_n, lf_n, data_latch_pulse_n_n, gout}, 13'h001f)
		rd(PPC_OFF, rv); `CHK(rv, 8'h00)
		rd(8'h00, rv); `CHK(rv, 8'h00)
	endtask
	task automatic t_port;
		wr(PPC_OFF, 8'h1d); wr(PDATA_OFF, 8'ha5); @(negedge clk_in);
		`CHK({oe_out, sel_n, init_n, lf_n}, 11'h7f8)
		`CHK(lines, 8'ha5)
		rd(PDATA_OFF, rv); `CHK(rv, 8'ha5)
	endtask
	task automatic t_strobe;
		wr(STAT_OFF, 8'h3f); wr(IMASK_OFF, 8'h21); wr(PPC_OFF, 8'h1f); n = 0;
		repeat (12) begin @(negedge clk_in); if (!data_latch_pulse_n_n) n++; end
		`CHK(n, 4)
		`CHK(got, 8'ha5)
		repeat (12) @(negedge clk_in);
		`CHK(irq_out, 1'b1)
		rd(STAT_OFF, rv); `CHK(rv, 8'h29)
		wr(IMASK_OFF, 8'h00); repeat (2) @(negedge clk_in); `CHK(irq_out, 1'b0)
		wr(STAT_OFF, 8'h3f); rd(STAT_OFF, rv); `CHK(rv, 8'h00)
		wr(PPC_OFF, 8'h00); repeat (2) @(posedge clk_in);
		rd(PDATA_OFF, rv); `CHK(rv, 8'h1f)
	endtask
	task automatic t_gio;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_in);
			{gin2, gin1, gin0} <= i ? 3'b010 : 3'b101; repeat (4) @(posedge clk_in);
			rd(GIO_OFF, rv); `CHK(rv & 8'h70, i ? 8'h20 : 8'h50)
		end
		@(posedge clk_in);
		{gin2, gin1, gin0} <= 3'b100;
		rd(GIO_OFF, rv); `CHK(rv & 8'h70, 8'h20)
		repeat (4) @(posedge clk_in);
		wr(PPC_OFF, 8'h20); wr(STAT_OFF, 8'h3f); @(posedge clk_in);
		gin1 <= 1'b1; gin0 <= 1'b1; fault_n_in <= 1'b0; repeat (6) @(posedge clk_in);
		rd(GIO_OFF, rv); `CHK(rv & 8'h70, 8'h40)
		rd(STAT_OFF, rv); `CHK(rv, 8'h16)
		wr(GIO_OFF, 8'h01); @(negedge clk_in); `CHK(gout, 1'b0)
		wr(GIO_OFF, 8'h00); @(negedge clk_in); `CHK(gout, 1'b1)
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset; t_port; t_strobe; t_gio;
		final_report;
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		failures++;
		final_report;
	end
endmodule
`default_nettype wire
